// ==== logic/slr_link.sv ====
// Rate matching transmit select and OPEN address frame receiver
`timescale 1ns/10ps

// Simple valid/ready FIFO for outgoing frame dwords
module slr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;

   assign inReady  = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];

   always_ff @(posedge core_clk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWrite) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (doRead)  rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule

module slr_link #(
   parameter int unsigned FIFO_DEPTH = slr_pkg::SLR_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // Link enable and rates
   input  wire logic                   linkEnable,
   input  wire logic [1:0]             linkRate,
   input  wire logic [1:0]             connRate,
   input  wire logic                   lostArbitration,
   input  wire logic                   skewSlot,
   input  wire logic                   throttleSlot,
   // Transmit requests from the connection control
   input  wire logic                   reqBreak,
   input  wire logic                   reqClose,
   input  wire logic [3:0]             closeArg,
   input  wire logic                   reqAccept,
   input  wire logic                   reqReject,
   input  wire logic [3:0]             rejectArg,
   input  wire logic                   frameValid,
   output logic                        frameReady,
   input  wire logic [31:0]            frameData,
   input  wire logic                   frameLast,
   // Transmit path to the phy
   output slr_pkg::slr_tx_dword_t      txDword,
   output logic                        frameSent,
   // Receive path from the phy
   input  wire slr_pkg::slr_rx_dword_t rxDword,
   output slr_pkg::slr_rx_dword_t      rxReport,
   // OPEN frame delivery
   output logic                        openValid,
   output logic [255:0]                openFrame
);
   import slr_pkg::*;

   // Transmit side
   logic        rateActive;
   logic        prevAlign;
   logic        fifoValid;
   logic [32:0] fifoOut;
   logic        fifoInReady;
   logic        fifoPop;
   wire  [32:0] fifoIn = {frameLast, frameData};

   assign frameReady = fifoInReady && linkEnable;

   slr_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) i_slr_fifo (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .inValid  (frameValid && linkEnable),
      .inReady  (fifoInReady),
      .inData   (fifoIn),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoOut)
   );

   wire rateNeeded = (linkRate == SLR_RATE_3G0) && (connRate == SLR_RATE_1G5);
   // Skew and throttle slots are owned by the phy; they neither count nor reset the window
   wire freeSlot   = linkEnable && !skewSlot && !throttleSlot;
   wire mustAlign  = rateActive && rateNeeded && !prevAlign;
   wire sendBreak  = reqBreak;
   wire sendClose  = !sendBreak && reqClose;
   wire sendAcc    = !sendBreak && !sendClose && reqAccept;
   wire sendRej    = !sendBreak && !sendClose && !sendAcc && reqReject;
   wire ctrlSend   = sendBreak || sendClose || sendAcc || sendRej;
   // A rate align steals the slot from frame and idle only; control primitives go first
   wire alignNow   = freeSlot && mustAlign && !ctrlSend;
   assign fifoPop  = freeSlot && !ctrlSend && !alignNow && fifoValid;
   wire eoafSent   = fifoPop && fifoOut[32];
   wire startMatch = eoafSent || (freeSlot && sendAcc);
   wire stopMatch  = (freeSlot && (sendBreak || sendClose)) || lostArbitration
                     || (rxDword.kind == SLR_RX_REJECT);

   slr_tx_dword_t next_txDword;
   always_comb begin
      next_txDword           = '0;
      next_txDword.valid     = freeSlot;
      next_txDword.kind      = SLR_TX_IDLE;
      next_txDword.rateAlign = alignNow;
      if (sendBreak) next_txDword.kind = SLR_TX_BREAK;
      else if (sendClose) begin
         next_txDword.kind = SLR_TX_CLOSE;
         next_txDword.arg  = closeArg;
      end else if (sendAcc) next_txDword.kind = SLR_TX_ACCEPT;
      else if (sendRej) begin
         next_txDword.kind = SLR_TX_REJECT;
         next_txDword.arg  = rejectArg;
      end else if (fifoPop) begin
         next_txDword.kind     = SLR_TX_FRAME;
         next_txDword.data     = fifoOut[31:0];
         next_txDword.frameEnd = fifoOut[32];
      end
      if (!freeSlot) next_txDword = '0;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txDword    <= '0;
         frameSent  <= 1'b0;
         rateActive <= 1'b0;
         prevAlign  <= 1'b1;
      end else begin
         txDword   <= next_txDword;
         frameSent <= eoafSent;
         if (!linkEnable || stopMatch) rateActive <= 1'b0;
         else if (startMatch) rateActive <= 1'b1;
         // Window restarts with a dword first after matching starts
         if (startMatch) prevAlign <= 1'b1;
         else if (freeSlot) prevAlign <= alignNow;
      end
   end

   // Receive report
   wire rxListed = (rxDword.kind != SLR_RX_NONE);
   slr_rx_dword_t next_rxReport;
   assign next_rxReport = (linkEnable && rxListed) ? rxDword : '0;

   // OPEN frame receiver
   logic         inFrame;
   logic [3:0]   dwCount;
   logic         overrun;
   logic [31:0]  crc;
   logic [31:0]  lastDw;
   logic [255:0] shiftReg;

   function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = (r[31] ^ d[i]) ? ((r << 1) ^ SLR_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   wire isSoaf = linkEnable && rxDword.kind == SLR_RX_SOAF;
   wire isData = linkEnable && inFrame && rxDword.kind == SLR_RX_DATA;
   wire isEoaf = linkEnable && inFrame && rxDword.kind == SLR_RX_EOAF;
   // CRC covers the seven payload dwords; the eighth dword is the CRC itself
   wire crcFeed = isData && (dwCount < 4'(SLR_OPEN_DWORDS - 1));
   wire crcOk   = (~crc == lastDw);
   // Dword 0 ends up in the top 32 bits of the shift register
   wire typeOk  = shiftReg[224 + SLR_TYPE_LSB +: 4] == SLR_FRAME_TYPE_OPEN;
   wire acceptF = isEoaf && !overrun && dwCount == 4'(SLR_OPEN_DWORDS) && typeOk && crcOk;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         inFrame   <= 1'b0;
         dwCount   <= '0;
         overrun   <= 1'b0;
         crc       <= SLR_CRC_INIT;
         lastDw    <= '0;
         shiftReg  <= '0;
         rxReport  <= '0;
         openValid <= 1'b0;
         openFrame <= '0;
      end else begin
         rxReport  <= next_rxReport;
         openValid <= acceptF;
         if (acceptF) openFrame <= shiftReg;
         if (isSoaf) begin
            inFrame <= 1'b1;
            dwCount <= '0;
            overrun <= 1'b0;
            crc     <= SLR_CRC_INIT;
         end else if (isEoaf || !linkEnable) begin
            inFrame <= 1'b0;
         end else if (isData) begin
            if (dwCount == 4'(SLR_OPEN_DWORDS)) overrun <= 1'b1;
            else dwCount <= dwCount + 4'h1;
            if (crcFeed) crc <= crcStep(crc, rxDword.data);
            lastDw   <= rxDword.data;
            shiftReg <= {shiftReg[223:0], rxDword.data};
         end
      end
   end

   AST_BREAK_FIRST: assert property (@(posedge core_clk) disable iff (!arst_n)
      (freeSlot && reqBreak) |=> txDword.kind == SLR_TX_BREAK)
      else $error("BREAK not chosen first");
   AST_CLOSE_ARG: assert property (@(posedge core_clk) disable iff (!arst_n)
      (freeSlot && !reqBreak && reqClose) |=> txDword.arg == $past(closeArg))
      else $error("CLOSE variant lost");
   AST_NO_TWO_DATA: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rateActive && rateNeeded && freeSlot && !prevAlign && !ctrlSend) |=> txDword.rateAlign)
      else $error("Rate window without align");
   AST_EQUAL_NONE: assert property (@(posedge core_clk) disable iff (!arst_n)
      !rateNeeded |=> !txDword.rateAlign)
      else $error("Align inserted at equal rates");
   AST_SKEW_UNTOUCHED: assert property (@(posedge core_clk) disable iff (!arst_n)
      skewSlot |=> !txDword.valid)
      else $error("Skew slot overwritten");
   AST_START_MATCH: assert property (@(posedge core_clk) disable iff (!arst_n)
      (eoafSent && !stopMatch && linkEnable) |=> rateActive)
      else $error("Matching not started after EOAF");
   AST_STOP_MATCH: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rateActive && lostArbitration) |=> !rateActive)
      else $error("Matching not stopped");
   AST_FRAME_SENT: assert property (@(posedge core_clk) disable iff (!arst_n)
      eoafSent |=> frameSent ##1 !frameSent)
      else $error("Frame sent pulse wrong");
   AST_DISABLED_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n)
      !linkEnable |=> !txDword.valid && rxReport.kind == SLR_RX_NONE && !openValid)
      else $error("Activity while link disabled");
   AST_OVERRUN_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
      (isEoaf && overrun) |=> !openValid)
      else $error("Overlong frame accepted");
   AST_ACCEPT_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(openValid) |-> $past(dwCount) == 4'(SLR_OPEN_DWORDS) && $past(crcOk))
      else $error("Bad frame accepted");
endmodule

// ==== logic/slr_pkg.sv ====
// Shared types and constants for the link-layer rate match and OPEN frame receive block
package slr_pkg;
   // Transmit request kinds; priority falls BREAK, CLOSE, ACCEPT, REJECT, FRAME, IDLE
   typedef enum logic [2:0] {
      SLR_TX_IDLE, SLR_TX_FRAME, SLR_TX_ACCEPT, SLR_TX_REJECT, SLR_TX_CLOSE, SLR_TX_BREAK
   } slr_tx_kind_t;

   // Received dword classes reported upward
   typedef enum logic [3:0] {
      SLR_RX_NONE, SLR_RX_SOAF, SLR_RX_DATA, SLR_RX_EOAF, SLR_RX_BROADCAST, SLR_RX_BREAK,
      SLR_RX_ACCEPT, SLR_RX_REJECT, SLR_RX_AIP, SLR_RX_CLOSE, SLR_RX_ERROR, SLR_RX_INVALID
   } slr_rx_kind_t;

   // Dword from the phy receiver; kind already decoded, arg is the variant
   typedef struct packed {
      slr_rx_kind_t kind;
      logic [3:0]   arg;
      logic [31:0]  data;
   } slr_rx_dword_t;

   // Dword handed to the phy transmitter
   typedef struct packed {
      logic         valid;
      slr_tx_kind_t kind;
      logic         rateAlign;
      logic         frameEnd;
      logic [3:0]   arg;
      logic [31:0]  data;
   } slr_tx_dword_t;

   localparam int unsigned SLR_OPEN_DWORDS   = 8;
   localparam logic [3:0]  SLR_FRAME_TYPE_OPEN = 4'h1;
   // Frame type nibble sits in the first byte sent, the top byte of dword 0
   localparam int unsigned SLR_TYPE_LSB     = 24;
   localparam logic [31:0] SLR_CRC_POLY     = 32'h04C11DB7;
   localparam logic [31:0] SLR_CRC_INIT     = 32'hFFFFFFFF;
   localparam int unsigned SLR_FIFO_DEPTH   = 16;
   localparam logic [1:0]  SLR_RATE_1G5     = 2'h0;
   localparam logic [1:0]  SLR_RATE_3G0     = 2'h1;
endpackage

// ==== tb/slr_phy_model.sv ====
// Far-side phy model: feeds decoded receive dwords to the block
`timescale 1ns/10ps
module slr_phy_model (
   // Clock
   input  wire logic                   core_clk,
   // Link dwords
   input  wire slr_pkg::slr_tx_dword_t txDword,
   output slr_pkg::slr_rx_dword_t      rxDword
);
   import slr_pkg::*;
   initial rxDword = '{SLR_RX_NONE, 4'h0, 32'h0};
   task automatic put(input slr_rx_kind_t k, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      rxDword = '{k, a, d};
   endtask
   // A released line holds nothing useful, so the data keeps turning over
   task automatic idle();
      @(posedge core_clk);
      #1;
      rxDword = '{SLR_RX_NONE, 4'h0, ~rxDword.data};
   endtask
endmodule

// ==== tb/slr_link_bench.sv ====
// Self-checking bench for rate match transmit select and OPEN frame receive
`timescale 1ns/10ps
module slr_link_bench;
   import slr_pkg::*;
   logic          core_clk, arst_n, linkEnable, lostArbitration, skewSlot, throttleSlot;
   logic          reqBreak, reqClose, reqAccept, reqReject, frameValid, frameReady;
   logic          frameLast, frameSent, openValid;
   logic [1:0]    linkRate, connRate;
   logic [3:0]    closeArg, rejectArg;
   logic [31:0]   frameData;
   logic [255:0]  openFrame;
   logic [31:0]   fr [8];
   slr_tx_dword_t txDword;
   slr_rx_dword_t rxDword, rxReport;
   int            num_errors, n_compared, nA, nG;

   slr_link i_slr_link (.core_clk, .arst_n, .linkEnable, .linkRate, .connRate,
      .lostArbitration, .skewSlot, .throttleSlot, .reqBreak, .reqClose, .closeArg,
      .reqAccept, .reqReject, .rejectArg, .frameValid, .frameReady, .frameData,
      .frameLast, .txDword, .frameSent, .rxDword, .rxReport, .openValid, .openFrame);
   slr_phy_model i_slr_phy_model (.core_clk, .txDword, .rxDword);

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic close_out();
      $display("Compared %0d, mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Address frame with type nibble and CRC; crcFlip spoils the CRC on purpose
   task automatic mk(input logic [3:0] ty, input logic [31:0] crcFlip);
      logic [31:0] crc;
      crc = SLR_CRC_INIT;
      for (int i = 0; i < 8; i++) fr[i] = 32'h5A3C0000 + 32'(i);
      fr[0][SLR_TYPE_LSB +: 4] = ty;
      for (int i = 0; i < 7; i++)
         for (int b = 31; b >= 0; b--)
            crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ fr[i][b]) ? SLR_CRC_POLY : 32'h0);
      fr[7] = ~crc ^ crcFlip;
   endtask
   // pre junk dwords then a second SOAF; err puts an ERROR among the data
   task automatic rx_frame(input int pre, input int n, input bit err);
      i_slr_phy_model.put(SLR_RX_SOAF, 4'h0, 32'h0);
      for (int i = 0; i < pre; i++) i_slr_phy_model.put(SLR_RX_DATA, 4'h0, ~fr[i]);
      if (pre > 0) i_slr_phy_model.put(SLR_RX_SOAF, 4'h0, 32'h0);
      for (int i = 0; i < n; i++) begin
         if (err && i == 3) i_slr_phy_model.put(SLR_RX_ERROR, 4'h0, 32'h0);
         i_slr_phy_model.put(SLR_RX_DATA, 4'h0, fr[i % 8]);
      end
      i_slr_phy_model.put(SLR_RX_EOAF, 4'h0, 32'h0);
      i_slr_phy_model.idle();
   endtask
   task automatic see_open(input logic want);
      logic got;
      got = 1'b0;
      repeat (6) begin
         if (openValid === 1'b1) begin
            got = 1'b1;
            check(openFrame, {fr[0], fr[1], fr[2], fr[3], fr[4], fr[5], fr[6], fr[7]}, "frame");
         end
         tick(1);
      end
      check(got, want, "frame accept");
   endtask
   task automatic t_report();
      slr_rx_dword_t d;
      for (int k = 1; k < 12; k++) begin
         d = '{slr_rx_kind_t'(k), 4'(k), 32'hC0DE0000 + 32'(k)};
         i_slr_phy_model.put(d.kind, d.arg, d.data);
         tick(1);
         check(rxReport, d, "rx report");
      end
      linkEnable = 1'b0;
      mk(SLR_FRAME_TYPE_OPEN, 32'h0);
      rx_frame(0, 8, 1'b0);
      check(rxReport.kind, SLR_RX_NONE, "report while off");
      see_open(1'b0);
      linkEnable = 1'b1;
      rx_frame(0, 8, 1'b1);
      see_open(1'b1);
      rx_frame(3, 8, 1'b0);
      see_open(1'b1);
      rx_frame(0, 9, 1'b0);
      see_open(1'b0);
      rx_frame(0, 7, 1'b0);
      see_open(1'b0);
      mk(4'h2, 32'h0);
      rx_frame(0, 8, 1'b0);
      see_open(1'b0);
      mk(SLR_FRAME_TYPE_OPEN, 32'h1);
      rx_frame(0, 8, 1'b0);
      see_open(1'b0);
      $display("Test receive done");
   endtask
   task automatic tx_pick(input logic [3:0] req, input slr_tx_kind_t k, input logic [3:0] a);
      {reqBreak, reqClose, reqAccept, reqReject} = req;
      tick(2);
      check(txDword.valid, 1'b1, "tx slot used");
      check(txDword.kind, k, "tx priority");
      if (k == SLR_TX_CLOSE || k == SLR_TX_REJECT) check(txDword.arg, a, "tx variant");
      check(txDword.rateAlign, 1'b0, "align at equal rates");
   endtask
   // Phy-owned slots mid-run must stay empty and not break the window
   task automatic run_aligns(input int n);
      logic prev;
      prev = 1'b1;
      nA = 0;
      nG = 0;
      for (int i = 0; i < n; i++) begin
         skewSlot = (i == 4);
         throttleSlot = (i == 7);
         tick(1);
         if (i == 4 || i == 7) check(txDword.valid, 1'b0, "phy slot");
         if (txDword.valid === 1'b1) begin
            if (txDword.rateAlign === 1'b1) nA++;
            else if (prev === 1'b0) nG++;
            prev = txDword.rateAlign;
         end
      end
   endtask
   task automatic push_frame(input int n);
      logic ok;
      frameValid = 1'b1;
      for (int i = 0; i < n; i++) begin
         frameData = 32'hF00D0000 + 32'(i);
         frameLast = (i == n - 1);
         do begin
            ok = frameReady;
            tick(1);
         end while (!ok);
      end
      frameValid = 1'b0;
      frameLast = 1'b0;
   endtask
   task automatic t_rate();
      connRate = SLR_RATE_1G5;
      push_frame(3);
      for (int i = 0; i < 20 && frameSent !== 1'b1; i++) tick(1);
      check(frameSent, 1'b1, "frame sent");
      check({txDword.frameEnd, txDword.data}, {1'b1, 32'hF00D0002}, "frame end");
      run_aligns(12);
      check({nG, nA > 3}, {32'h0, 1'b1}, "window after EOAF");
      reqClose = 1'b1;
      tick(2);
      reqClose = 1'b0;
      run_aligns(10);
      check(nA, 0, "stop on close");
      reqAccept = 1'b1;
      tick(1);
      reqAccept = 1'b0;
      run_aligns(12);
      check({nG, nA > 3}, {32'h0, 1'b1}, "window after accept");
      lostArbitration = 1'b1;
      tick(1);
      lostArbitration = 1'b0;
      run_aligns(10);
      check(nA, 0, "stop on lost arbitration");
      reqAccept = 1'b1;
      tick(1);
      reqAccept = 1'b0;
      i_slr_phy_model.put(SLR_RX_REJECT, 4'h1, 32'h0);
      i_slr_phy_model.idle();
      run_aligns(10);
      check(nA, 0, "stop on reject received");
      $display("Test rate match done");
   endtask
   task automatic t_fifo();
      int cnt;
      cnt = 0;
      reqBreak = 1'b1;
      tick(2);
      frameValid = 1'b1;
      for (int i = 0; i < 20; i++) begin
         nA = frameReady;
         tick(1);
         cnt += nA;
      end
      frameValid = 1'b0;
      check(cnt, SLR_FIFO_DEPTH, "fifo fill");
      reqBreak = 1'b0;
      cnt = 0;
      for (int i = 0; i < 40; i++) begin
         tick(1);
         if (txDword.valid === 1'b1 && txDword.kind === SLR_TX_FRAME) cnt++;
      end
      check(cnt, SLR_FIFO_DEPTH, "fifo drain");
      $display("Test transmit done");
   endtask

   initial begin
      {arst_n, linkEnable, lostArbitration, skewSlot, throttleSlot} = '0;
      {reqBreak, reqClose, reqAccept, reqReject, frameValid, frameLast} = '0;
      linkRate = SLR_RATE_3G0;
      connRate = SLR_RATE_3G0;
      closeArg = 4'h2;
      rejectArg = 4'h5;
      frameData = 32'h0;
      num_errors = 0;
      n_compared = 0;
      tick(16);
      check({txDword, frameSent, openValid, rxReport}, '0, "reset values");
      arst_n = 1'b1;
      linkEnable = 1'b1;
      tick(2);
      t_report();
      tx_pick(4'hF, SLR_TX_BREAK, 4'h0);
      tx_pick(4'h7, SLR_TX_CLOSE, 4'h2);
      tx_pick(4'h3, SLR_TX_ACCEPT, 4'h0);
      tx_pick(4'h1, SLR_TX_REJECT, 4'h5);
      tx_pick(4'h0, SLR_TX_IDLE, 4'h0);
      t_fifo();
      t_rate();
      close_out();
   end
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
endmodule
